// file: rtl/sacc_pkg.sv
package sacc_pkg;

  // Bus timing and conversion figures.
  localparam int CLK_PERIOD_NS      = 10;
  localparam int THROUGHPUT_NS      = 3000;
  localparam int BUSY_DELAY_MAX_NS  = 80;
  localparam int DATA_SETUP_MIN_NS  = 32;
  localparam int CONV_TIME_NS       = 2450;
  localparam int SAR_BITS           = 16;

  // Cycle counts derived from the figures above.
  localparam int BUSY_DELAY_CYC     = (BUSY_DELAY_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                      (BUSY_DELAY_MAX_NS / CLK_PERIOD_NS);
  localparam int DATA_SETUP_CYC     = (DATA_SETUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC           = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int THROUGHPUT_CYC     = THROUGHPUT_NS / CLK_PERIOD_NS;
  localparam int BIT_CYC            = CONV_CYC / SAR_BITS;
  localparam int CNT_W              = 10;

  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;

  typedef enum logic [1:0]
  {
    ST_IDLE    = 2'b00,
    ST_CONVERT = 2'b01,
    ST_SETTLE  = 2'b10
  } sacc_state_t;

endpackage : sacc_pkg

// file: rtl/sacc_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Three-stage synchroniser; the output changes only once stages two and three agree.
module sacc_sync
(
  input  wire logic clk,   // Core clock.
  input  wire logic rst_n, // Asynchronous reset, active low.
  input  wire logic din,   // Asynchronous input.
  output var  logic dout   // Filtered synchronous level.
);

  logic [2:0] stg_q;
  logic [2:0] stg_d;
  logic       out_q;
  logic       out_d;

  always_comb
  begin
    stg_d = {stg_q[1:0], din};
    out_d = (stg_q[1] == stg_q[2]) ? stg_q[2] : out_q;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stg_q <= 3'h7;
      out_q <= 1'b1;
    end
    else
    begin
      stg_q <= stg_d;
      out_q <= out_d;
    end
  end

  assign dout = out_q;

endmodule : sacc_sync

`default_nettype wire

// file: rtl/sacc_top.sv
// Behaviour
// - A falling conv_start_n with chip select low and power_down_n high starts a conversion and samples.
// - Acquisition plus conversion completes within 3 us for back-to-back starts.
// - Busy output goes low within 80 ns of the start edge.
// - The new result is on the latch at least 32 ns before busy rises.
// - Result outputs float whenever chip select is high.
// - Busy is low for the whole conversion and high otherwise.
// - Result outputs drive only while read and chip select are both low.
// - power_down_n low means shutdown: nap with select low, sleep with it high.
// - Start edges during a conversion are ignored; no restart.
`timescale 1ns/100ps
`default_nettype none

module sacc_top
(
  input  wire logic        CORE_CLK,       // Core clock, 100 MHz.
  input  wire logic        NRST,           // Asynchronous reset, active low.
  input  wire logic        CS_N,           // Chip select pin, active low.
  input  wire logic        RD_N,           // Read pin, active low.
  input  wire logic        CONV_START_N,   // Convert start pin, active low.
  input  wire logic        POWER_DOWN_N,   // Power down pin, active low.
  input  wire logic        COMP_IN,        // Comparator decision from the analog core.
  output var  logic        BUSY_N,         // Status, low while converting.
  output var  logic [15:0] RESULT_BITS,    // Result bus output values.
  output var  logic [15:0] RESULT_OE,      // Result bus output enables, high drives.
  output var  logic        SAMPLE_HOLD,    // High holds the sampled input.
  output var  logic [15:0] DAC_CODE,       // Trial code for the capacitive DAC.
  output var  logic        NAP_MODE,       // Nap shutdown active.
  output var  logic        SLEEP_MODE      // Sleep shutdown active.
);

  logic cs_n_s;
  logic rd_n_s;
  logic cst_n_s;
  logic pd_n_s;
  logic comp_s;

  sacc_sync u_sync_cs  (.clk(CORE_CLK), .rst_n(NRST), .din(CS_N),         .dout(cs_n_s));
  sacc_sync u_sync_rd  (.clk(CORE_CLK), .rst_n(NRST), .din(RD_N),         .dout(rd_n_s));
  sacc_sync u_sync_cst (.clk(CORE_CLK), .rst_n(NRST), .din(CONV_START_N), .dout(cst_n_s));
  sacc_sync u_sync_pd  (.clk(CORE_CLK), .rst_n(NRST), .din(POWER_DOWN_N), .dout(pd_n_s));
  sacc_sync u_sync_cmp (.clk(CORE_CLK), .rst_n(NRST), .din(COMP_IN),      .dout(comp_s));

  sacc_pkg::sacc_state_t  state_q;
  sacc_pkg::sacc_state_t  state_d;
  logic [sacc_pkg::CNT_W-1:0] cnt_q;
  logic [sacc_pkg::CNT_W-1:0] cnt_d;
  logic [4:0]             bit_q;
  logic [4:0]             bit_d;
  logic [15:0]            sar_q;
  logic [15:0]            sar_d;
  logic [15:0]            latch_q;
  logic [15:0]            latch_d;
  logic                   cst_prev_q;
  logic                   cst_prev_d;
  logic                   busy_n_q;
  logic                   busy_n_d;
  logic [15:0]            res_q;
  logic [15:0]            res_d;
  logic [15:0]            oe_q;
  logic [15:0]            oe_d;
  logic                   hold_q;
  logic                   hold_d;
  logic                   nap_q;
  logic                   nap_d;
  logic                   sleep_q;
  logic                   sleep_d;
  logic                   start_edge;

  // Synchronised edge plus registered busy gives 5 cycles, well inside the 80 ns bound.
  assign start_edge = cst_prev_q & ~cst_n_s;

  always_comb
  begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    bit_d      = bit_q;
    sar_d      = sar_q;
    latch_d    = latch_q;
    cst_prev_d = cst_n_s;
    hold_d     = hold_q;
    case (state_q)
      sacc_pkg::ST_IDLE:
      begin
        if (start_edge && !cs_n_s && pd_n_s)
        begin
          state_d = sacc_pkg::ST_CONVERT;
          hold_d  = 1'b1;
          cnt_d   = sacc_pkg::CNT_ZERO;
          bit_d   = 5'h0f;
          sar_d   = 16'h8000;
        end
      end
      sacc_pkg::ST_CONVERT:
      begin
        if (cnt_q == sacc_pkg::CNT_W'(sacc_pkg::BIT_CYC - 1))
        begin
          cnt_d = sacc_pkg::CNT_ZERO;
          sar_d[bit_q[3:0]] = comp_s;
          if (bit_q == 5'h00)
          begin
            latch_d = {sar_q[15:1], comp_s};
            state_d = sacc_pkg::ST_SETTLE;
          end
          else
          begin
            sar_d[bit_q[3:0] - 4'h1] = 1'b1;
            bit_d = bit_q - 5'h01;
          end
        end
        else
        begin
          cnt_d = cnt_q + 10'h001;
        end
      end
      sacc_pkg::ST_SETTLE:
      begin
        if (cnt_q == sacc_pkg::CNT_W'(sacc_pkg::DATA_SETUP_CYC))
        begin
          state_d = sacc_pkg::ST_IDLE;
          hold_d  = 1'b0;
          cnt_d   = sacc_pkg::CNT_ZERO;
        end
        else
        begin
          cnt_d = cnt_q + 10'h001;
        end
      end
      default:
      begin
        state_d = sacc_pkg::ST_IDLE;
        hold_d  = 1'b0;
      end
    endcase
    busy_n_d = (state_d == sacc_pkg::ST_IDLE);
    oe_d  = {16{~cs_n_s & ~rd_n_s}};
    res_d = latch_q;
    nap_d   = ~pd_n_s & ~cs_n_s;
    sleep_d = ~pd_n_s & cs_n_s;
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_q    <= sacc_pkg::ST_IDLE;
      cnt_q      <= sacc_pkg::CNT_ZERO;
      bit_q      <= 5'h00;
      sar_q      <= sacc_pkg::RESULT_RST;
      latch_q    <= sacc_pkg::RESULT_RST;
      cst_prev_q <= 1'b1;
      busy_n_q   <= 1'b1;
      res_q      <= sacc_pkg::RESULT_RST;
      oe_q       <= 16'h0000;
      hold_q     <= 1'b0;
      nap_q      <= 1'b0;
      sleep_q    <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      bit_q      <= bit_d;
      sar_q      <= sar_d;
      latch_q    <= latch_d;
      cst_prev_q <= cst_prev_d;
      busy_n_q   <= busy_n_d;
      res_q      <= res_d;
      oe_q       <= oe_d;
      hold_q     <= hold_d;
      nap_q      <= nap_d;
      sleep_q    <= sleep_d;
    end
  end

  assign BUSY_N      = busy_n_q;
  assign RESULT_BITS = res_q;
  assign RESULT_OE   = oe_q;
  assign SAMPLE_HOLD = hold_q;
  assign DAC_CODE    = sar_q;
  assign NAP_MODE    = nap_q;
  assign SLEEP_MODE  = sleep_q;

endmodule : sacc_top

`default_nettype wire

// file: verification/sacc_comp_model.sv
`timescale 1ns/100ps
`default_nettype none
// Ideal comparator: keeps a trial bit while the code stays at or below the target,
// so a finished conversion must equal the target.
module sacc_comp_model
(
  input  wire logic [15:0] dac_code, // Trial code.
  input  wire logic [15:0] target,   // Input level as a code.
  output var  logic        comp      // Keep decision.
);
  assign comp = (dac_code <= target);
endmodule : sacc_comp_model
`default_nettype wire

// file: verification/sacc_properties.sv
`timescale 1ns/100ps
`default_nettype none
module sacc_properties
(
  input wire logic        CORE_CLK,     // Clock.
  input wire logic        NRST,         // Reset.
  input wire logic        CS_N,         // Select.
  input wire logic        RD_N,         // Read.
  input wire logic        CONV_START_N, // Start.
  input wire logic        POWER_DOWN_N, // Shutdown.
  input wire logic        BUSY_N,       // Status.
  input wire logic [15:0] RESULT_BITS,  // Result.
  input wire logic [15:0] RESULT_OE,    // Enables.
  input wire logic        NAP_MODE,     // Nap.
  input wire logic        SLEEP_MODE    // Sleep.
);
  logic [9:0] low_q;
  logic [9:0] low_d;
  always_comb low_d = BUSY_N ? 10'h000 : low_q + 10'h001;
  always_ff @(posedge CORE_CLK or negedge NRST)
    if (!NRST) low_q <= 10'h000;
    else low_q <= low_d;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  // Inputs pass a synchroniser, so select and start must be settled first.
  sequence start_seen;
    (!CS_N && POWER_DOWN_N && CONV_START_N)[*4] ##1 (!CS_N && POWER_DOWN_N && !CONV_START_N && BUSY_N);
  endsequence
  a_busy_start: assert property (start_seen |-> ##[1:8] !BUSY_N)
    else $error("busy late");
  a_busy_len: assert property ($rose(BUSY_N) |-> low_q >= 10'h0f1 && low_q <= 10'h0f6)
    else $error("busy length");
  a_no_restart: assert property (!BUSY_N |-> low_q <= 10'h0f6)
    else $error("restart");
  a_data_ready: assert property ($rose(BUSY_N) |-> RESULT_BITS == $past(RESULT_BITS, 4))
    else $error("data late");
  a_result_hold: assert property (BUSY_N && $past(BUSY_N) |-> $stable(RESULT_BITS))
    else $error("result moved");
  a_bus_float: assert property ((CS_N || RD_N)[*7] |-> RESULT_OE == 16'h0000)
    else $error("bus driven");
  a_bus_drive: assert property ((!CS_N && !RD_N)[*7] |-> RESULT_OE == 16'hffff)
    else $error("bus idle");
  a_nap_mode: assert property ((!POWER_DOWN_N && !CS_N)[*7] |-> NAP_MODE && !SLEEP_MODE)
    else $error("nap");
  a_sleep_mode: assert property ((!POWER_DOWN_N && CS_N)[*7] |-> SLEEP_MODE && !NAP_MODE)
    else $error("sleep");
endmodule : sacc_properties
bind sacc_top sacc_properties u_props (.CORE_CLK(CORE_CLK), .NRST(NRST), .CS_N(CS_N), .RD_N(RD_N),
  .CONV_START_N(CONV_START_N), .POWER_DOWN_N(POWER_DOWN_N), .BUSY_N(BUSY_N), .RESULT_BITS(RESULT_BITS),
  .RESULT_OE(RESULT_OE), .NAP_MODE(NAP_MODE), .SLEEP_MODE(SLEEP_MODE));
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic CORE_CLK = 1'b0, NRST = 1'b0, CS_N = 1'b1, RD_N = 1'b1, CONV_START_N = 1'b1;
  logic POWER_DOWN_N = 1'b1, prev_busy = 1'b1, COMP_IN, BUSY_N, NAP_MODE, SLEEP_MODE, SAMPLE_HOLD;
  logic [15:0] RESULT_BITS, RESULT_OE, DAC_CODE, target = 16'h0000;
  logic [15:0] exp_q[$];
  int n_errors = 0, n_checks = 0, seed = 17, i, k;
  always #5 CORE_CLK = ~CORE_CLK;
  sacc_top DUT (.CORE_CLK(CORE_CLK), .NRST(NRST), .CS_N(CS_N), .RD_N(RD_N), .CONV_START_N(CONV_START_N),
    .POWER_DOWN_N(POWER_DOWN_N), .COMP_IN(COMP_IN), .BUSY_N(BUSY_N), .RESULT_BITS(RESULT_BITS),
    .RESULT_OE(RESULT_OE), .SAMPLE_HOLD(SAMPLE_HOLD), .DAC_CODE(DAC_CODE),
    .NAP_MODE(NAP_MODE), .SLEEP_MODE(SLEEP_MODE));
  sacc_comp_model u_comp (.dac_code(DAC_CODE), .target(target), .comp(COMP_IN));
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      n_errors++;
    end
  endtask : check
  task report_and_stop;
    check("pending", 16'(exp_q.size()), 16'h0000);
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  // Start pulse is short so the host keeps the accuracy window; extra adds an edge mid-conversion.
  task convert(input logic [15:0] t, input bit extra);
    @(posedge CORE_CLK);
    target <= t;
    exp_q.push_back(t);
    CONV_START_N <= 1'b0;
    repeat (5) @(posedge CORE_CLK);
    CONV_START_N <= 1'b1;
    // Busy is read one edge after it is launched, so the wait below cannot see the idle level.
    @(posedge CORE_CLK);
    check("busy low", {15'h0000, BUSY_N}, 16'h0000);
    check("hold", {15'h0000, SAMPLE_HOLD}, 16'h0001);
    i = 6;
    if (extra)
    begin
      repeat (40) @(posedge CORE_CLK);
      CONV_START_N <= 1'b0;
      repeat (5) @(posedge CORE_CLK);
      CONV_START_N <= 1'b1;
      i = 51;
    end
    while (i < 300 && BUSY_N !== 1'b1)
    begin
      @(posedge CORE_CLK);
      i++;
    end
    if (i == 300)
    begin
      n_errors++;
      report_and_stop();
    end
    check("released", {15'h0000, SAMPLE_HOLD}, 16'h0000);
  endtask : convert
  task pulse_refused(input string name);
    CONV_START_N <= 1'b0;
    repeat (20) @(posedge CORE_CLK);
    check(name, {15'h0000, BUSY_N}, 16'h0001);
    CONV_START_N <= 1'b1;
    repeat (8) @(posedge CORE_CLK);
  endtask : pulse_refused
  always @(posedge CORE_CLK)
  begin
    if (NRST && prev_busy === 1'b0 && BUSY_N === 1'b1 && exp_q.size() > 0)
      check("result", RESULT_BITS, exp_q.pop_front());
    prev_busy <= BUSY_N;
  end
  initial
  begin
    repeat (8) @(posedge CORE_CLK);
    NRST <= 1'b1;
    CS_N <= 1'b0;
    repeat (8) @(posedge CORE_CLK);
    convert(16'h0000, 1'b0);
    convert(16'hffff, 1'b0);
    convert(16'h8001, 1'b1);
    for (k = 0; k < 4; k++) convert(16'($random(seed)), 1'b0);
    RD_N <= 1'b0;
    repeat (8) @(posedge CORE_CLK);
    check("enable", RESULT_OE, 16'hffff);
    check("read", RESULT_BITS, target);
    RD_N <= 1'b1;
    CS_N <= 1'b1;
    repeat (8) @(posedge CORE_CLK);
    check("float", RESULT_OE, 16'h0000);
    pulse_refused("deselected");
    POWER_DOWN_N <= 1'b0;
    repeat (8) @(posedge CORE_CLK);
    check("sleep", {14'h0000, NAP_MODE, SLEEP_MODE}, 16'h0001);
    CS_N <= 1'b0;
    repeat (8) @(posedge CORE_CLK);
    check("nap", {14'h0000, NAP_MODE, SLEEP_MODE}, 16'h0002);
    pulse_refused("napping");
    POWER_DOWN_N <= 1'b1;
    repeat (40) @(posedge CORE_CLK);
    check("awake", {14'h0000, NAP_MODE, SLEEP_MODE}, 16'h0000);
    convert(16'h1234, 1'b0);
    // Let the result watcher take the last result before the verdict.
    repeat (2) @(posedge CORE_CLK);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
